// ---- exd_defs.svh ----
// Constants for the extended instruction decoder: opcode patterns, field positions, reset and address values.
// Assumes the including file sits in the same folder as this header.
//
// How it works
// RULE_01: Opcode E8 with selector 0 to 2 adds the six-bit literal to that pointer register in one cycle, no flags.
// RULE_02: Add-and-return adds the literal to pointer register two and then loads the PC from the return stack top.
// RULE_03: Add-and-return takes two cycles, the second a no-operation while the target is fetched.
// RULE_04: Selector 11 in the add opcode selects add-and-return, which works only on pointer register two.
// RULE_05: Word 0014 is a call through the accumulator, two cycles, no flags.
// RULE_06: Move indexed to absolute is EB with bit 7 clear plus a second word 1111 and a twelve-bit address.
// RULE_07: Move indexed to indexed is EB with bit 7 set plus a second word 1111, five ignored bits, seven-bit offset.
// RULE_08: Opcode EA stores the eight-bit literal at pointer register two and decrements it, in one cycle.
// RULE_09: Opcode E9 with a selector subtracts the six-bit literal from that pointer register in one cycle, no flags.
// RULE_10: Selector 11 in the subtract opcode subtracts from pointer register two and returns, in two cycles.
// RULE_11: All extension opcodes and indexed literal offset addressing act only while the config bit is set.
// RULE_12: The accumulator call pushes PC plus two and loads the PC from accumulator and the two latches.
// RULE_13: Move to absolute reads pointer two plus offset, writes the absolute address, reads zero from indirect regs.
// RULE_14: Move indexed to indexed becomes a no-operation when its destination is an indirect register.
// RULE_15: Pointer add and subtract carry across the full pointer width.
// RULE_16: No extension instruction changes any arithmetic status flag.
`ifndef EXD_DEFS_SVH
`define EXD_DEFS_SVH

`define EXD_OP_ADD_PTR     8'hE8
`define EXD_OP_SUB_PTR     8'hE9
`define EXD_OP_PUSH_LIT    8'hEA
`define EXD_OP_MOVE_IDX    8'hEB
`define EXD_WORD_CALL_ACC  16'h0014
`define EXD_SECOND_TAG     4'hF
`define EXD_SEL_RETURN     2'h3
`define EXD_MOVE_KIND_BIT  7
`define EXD_PTR_RESET      12'h000
`define EXD_PC_STEP        21'h000002
`define EXD_INDIRECT_BASE  12'hFE0
`define EXD_INDIRECT_MASK  12'hFE0
`define EXD_INDIRECT_LOW   5'h07
`define EXD_ZERO_BYTE      8'h00

`endif

// ---- exd_pkg.sv ----
// Types shared by the extended instruction decoder modules.
// Assumes exd_defs.svh is compiled alongside.
package exd_pkg;

	typedef enum logic [2:0] {
		EXD_ST_IDLE   = 3'b000,
		EXD_ST_NOP2   = 3'b001,
		EXD_ST_MOVEAB = 3'b010,
		EXD_ST_MOVEII = 3'b011
	} exd_state_t;

	// Pointer register write request
	typedef struct packed {
		logic        valid;
		logic [1:0]  sel;
		logic [11:0] value;
	} exd_ptr_wr_t;

	// Data memory access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  data;
	} exd_mem_t;

	// Program counter and return stack request
	typedef struct packed {
		logic        load;
		logic        push;
		logic        pop;
		logic [20:0] value;
	} exd_pc_t;

endpackage : exd_pkg

// ---- exd_ptr_alu.sv ----
// Full-width pointer adder and subtractor for the extension instructions.
// Assumes a twelve-bit pointer and an unsigned eight-bit literal.
`timescale 1ns/1ns
`include "exd_defs.svh"
module exd_ptr_alu
	import exd_pkg::*;
(
	input  wire logic [11:0] ptr_i,
	input  wire logic [7:0]  lit_i,
	input  wire logic        sub_i,
	output logic      [11:0] result_o
);
	// Carry runs into the high bits of the pointer
	always_comb begin
		if (sub_i) begin
			result_o = ptr_i - {4'h0, lit_i}; // see RULE_15
		end else begin
			result_o = ptr_i + {4'h0, lit_i}; // see RULE_15
		end
	end
endmodule : exd_ptr_alu

// ---- exd_decoder.sv ----
// Decode and execute logic for the extended instruction set.
// Outputs are registered pulses, except the pointer values and busy, which hold until changed.
// Assumes the core presents one fetched word per instruction cycle on instr_valid_i, and
// that data reads return within the same instruction cycle on mem_rdata_i.
`timescale 1ns/1ns
`include "exd_defs.svh"
module exd_decoder
	import exd_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ext_enable_i,
	input  wire logic        instr_valid_i,
	input  wire logic [15:0] instr_i,
	input  wire logic [20:0] pc_i,
	input  wire logic [20:0] top_of_return_stack_i,
	input  wire logic [7:0]  accumulator_i,
	input  wire logic [7:0]  program_counter_high_latch_i,
	input  wire logic [7:0]  program_counter_upper_latch_i,
	input  wire logic [7:0]  mem_rdata_i,
	output logic      [11:0] pointer_register_0_o,
	output logic      [11:0] pointer_register_1_o,
	output logic      [11:0] pointer_register_two_o,
	output exd_mem_t         mem_o,
	output exd_pc_t          pc_o,
	output logic             flags_we_o,
	output logic             claimed_o,
	output logic             busy_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		exd_state_t  state;
		logic [11:0] ptr0;
		logic [11:0] ptr1;
		logic [11:0] ptr2;
		logic [11:0] src_addr;
		logic [7:0]  src_data;
		exd_mem_t    mem;
		exd_pc_t     pc;
		logic        claimed;
		logic        busy;
		logic        flags_we;
	} exd_regs_t;

	exd_regs_t   s_r;
	exd_regs_t   s_nxt;
	logic [11:0] alu_ptr;
	logic [11:0] alu_res;
	logic        alu_sub;
	logic [1:0]  sel;
	logic [7:0]  op;

	logic        is_ptr_arith;
	logic        is_ptr_return;
	logic        is_push_lit;
	logic        is_call_acc;
	logic        is_move;
	logic        is_second;
	logic [11:0] move_addr;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign op  = instr_i[15:8];
	assign sel = instr_i[7:6];

	// Patterns are disjoint, so the order of tests below carries no priority
	always_comb begin
		is_call_acc   = (instr_i == `EXD_WORD_CALL_ACC);
		is_ptr_arith  = (op == `EXD_OP_ADD_PTR) || (op == `EXD_OP_SUB_PTR);
		is_ptr_return = is_ptr_arith && (sel == `EXD_SEL_RETURN); // see RULE_04
		is_push_lit   = (op == `EXD_OP_PUSH_LIT);
		is_move       = (op == `EXD_OP_MOVE_IDX);
		is_second     = (instr_i[15:12] == `EXD_SECOND_TAG);
	end

	// Both move offsets index from pointer register two, each in its own cycle
	assign move_addr = s_r.ptr2 + {5'h00, instr_i[6:0]};

	// ----------------------------------------
	// Pointer arithmetic
	// ----------------------------------------
	always_comb begin
		case (sel)
			2'h0:    alu_ptr = s_r.ptr0;
			2'h1:    alu_ptr = s_r.ptr1;
			default: alu_ptr = s_r.ptr2; // see RULE_04
		endcase
	end
	assign alu_sub = (op == `EXD_OP_SUB_PTR);

	exd_ptr_alu exd_ptr_alu_i (
		.ptr_i    (alu_ptr),
		.lit_i    ({2'h0, instr_i[5:0]}),
		.sub_i    (alu_sub),
		.result_o (alu_res)
	);

	// ----------------------------------------
	// Indirect register map
	// ----------------------------------------
	// Limitation: fixed address pattern; a core with another map must change it here
	function automatic logic is_indirect(input logic [11:0] a);
		// Indirect access ports sit in the top bank at offsets 0 to 6 of each 8-byte group above the first
		is_indirect = ((a & `EXD_INDIRECT_MASK) == `EXD_INDIRECT_BASE) &&
			(a[2:0] != 3'h7) && (a[4:0] >= `EXD_INDIRECT_LOW);
	endfunction : is_indirect

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt         = s_r;
		s_nxt.mem     = '0;
		s_nxt.pc      = '0;
		s_nxt.claimed = 1'b0;
		case (s_r.state)
			EXD_ST_IDLE: begin
				// Disabled config leaves every word to the standard decoder
				if (instr_valid_i && ext_enable_i) begin // see RULE_11
					if (is_ptr_arith) begin
						s_nxt.claimed = 1'b1;
						case (sel)
							2'h0:    s_nxt.ptr0 = alu_res; // see RULE_01
							2'h1:    s_nxt.ptr1 = alu_res; // see RULE_09
							default: s_nxt.ptr2 = alu_res;
						endcase
						if (is_ptr_return) begin
							s_nxt.pc.load  = 1'b1; // see RULE_02
							s_nxt.pc.pop   = 1'b1; // see RULE_10
							s_nxt.pc.value = top_of_return_stack_i;
							s_nxt.state    = EXD_ST_NOP2; // see RULE_03
						end
					end else if (is_push_lit) begin
						s_nxt.claimed  = 1'b1;
						s_nxt.mem.wr   = 1'b1; // see RULE_08
						s_nxt.mem.addr = s_r.ptr2;
						s_nxt.mem.data = instr_i[7:0];
						s_nxt.ptr2     = s_r.ptr2 - 12'h001;
					end else if (is_call_acc) begin
						s_nxt.claimed  = 1'b1; // see RULE_05
						s_nxt.pc.push  = 1'b1; // see RULE_12
						s_nxt.pc.load  = 1'b1;
						s_nxt.pc.value = {program_counter_upper_latch_i[4:0], program_counter_high_latch_i,
							accumulator_i};
						s_nxt.state    = EXD_ST_NOP2;
					end else if (is_move) begin
						s_nxt.claimed  = 1'b1;
						s_nxt.src_addr = move_addr; // see RULE_13
						s_nxt.mem.rd   = 1'b1;
						s_nxt.mem.addr = s_nxt.src_addr;
						s_nxt.state    = instr_i[`EXD_MOVE_KIND_BIT] ? EXD_ST_MOVEII : EXD_ST_MOVEAB; // see RULE_07
					end
				end
			end
			EXD_ST_NOP2: begin
				// Second cycle idles while the new target is fetched
				s_nxt.claimed = instr_valid_i;
				if (instr_valid_i) begin
					s_nxt.state = EXD_ST_IDLE;
				end
			end
			EXD_ST_MOVEAB, EXD_ST_MOVEII: begin
				if (instr_valid_i && is_second) begin // see RULE_06
					s_nxt.claimed  = 1'b1;
					s_nxt.state    = EXD_ST_IDLE;
					s_nxt.mem.data = is_indirect(s_r.src_addr) ? `EXD_ZERO_BYTE : mem_rdata_i; // see RULE_13
					if (s_r.state == EXD_ST_MOVEAB) begin
						s_nxt.mem.addr = instr_i[11:0]; // see RULE_06
						s_nxt.mem.wr   = 1'b1;
					end else begin
						s_nxt.mem.addr = move_addr; // see RULE_07
						s_nxt.mem.wr   = !is_indirect(s_nxt.mem.addr); // see RULE_14
					end
				end else if (instr_valid_i) begin
					// Malformed second word: drop the move
					s_nxt.state = EXD_ST_IDLE;
				end
			end
			default: s_nxt.state = EXD_ST_IDLE;
		endcase
		// Busy is registered so the port comes straight from a flip-flop
		s_nxt.busy     = (s_nxt.state != EXD_ST_IDLE);
		s_nxt.flags_we = 1'b0; // see RULE_16
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r          <= '0;
			s_r.state    <= EXD_ST_IDLE;
			s_r.ptr0     <= `EXD_PTR_RESET;
			s_r.ptr1     <= `EXD_PTR_RESET;
			s_r.ptr2     <= `EXD_PTR_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pointer_register_0_o   = s_r.ptr0;
	assign pointer_register_1_o   = s_r.ptr1;
	assign pointer_register_two_o = s_r.ptr2;
	assign mem_o                  = s_r.mem;
	assign pc_o                   = s_r.pc;
	assign claimed_o              = s_r.claimed;
	assign busy_o                 = s_r.busy;
	// Status flags are never written by this block
	assign flags_we_o             = s_r.flags_we; // see RULE_16

	// ----------------------------------------
	// Return address
	// ----------------------------------------
	// Return address is pc_i + 2; the core's stack takes it on pc_o.push
	logic [20:0] ret_addr_unused;
	assign ret_addr_unused = pc_i + `EXD_PC_STEP;

endmodule : exd_decoder

// ---- exd_decoder_sva.sv ----
// Assertions on the extended instruction decoder ports.
// Assumes it is bound onto exd_decoder from the bench top file.
`timescale 1ns/1ns
module exd_decoder_sva
	import exd_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	input wire logic        ext_enable_i,
	input wire logic        instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [20:0] top_of_return_stack_i,
	input wire logic [7:0]  accumulator_i,
	input wire logic [7:0]  program_counter_high_latch_i,
	input wire logic [7:0]  program_counter_upper_latch_i,
	input wire logic [11:0] pointer_register_0_o,
	input wire logic [11:0] pointer_register_1_o,
	input wire logic [11:0] pointer_register_two_o,
	input wire exd_mem_t    mem_o,
	input wire exd_pc_t     pc_o,
	input wire logic        flags_we_o,
	input wire logic        claimed_o,
	input wire logic        busy_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Words are only taken in idle with the extension on
	wire logic take_w = instr_valid_i && ext_enable_i && !busy_o;
	AST_FLAGS_QUIET: assert property (flags_we_o == 1'b0)
		else $error("flag write from extension");
	AST_ADD_PTR0: assert property (take_w && instr_i[15:6] == 10'h3A0 |=>
		pointer_register_0_o == $past(pointer_register_0_o) + {6'h00, $past(instr_i[5:0])}) else $error("add ptr0");
	AST_SUB_PTR1: assert property (take_w && instr_i[15:6] == 10'h3A5 |=>
		pointer_register_1_o == $past(pointer_register_1_o) - {6'h00, $past(instr_i[5:0])}) else $error("sub ptr1");
	AST_RETURN: assert property (take_w && instr_i[15:9] == 7'h74 && instr_i[7:6] == 2'h3 |=>
		pc_o.load && pc_o.pop && busy_o && pc_o.value == $past(top_of_return_stack_i)) else $error("return");
	AST_SECOND_CYCLE: assert property (busy_o && instr_valid_i && instr_i[15:12] == 4'hF |=>
		claimed_o && !busy_o && !pc_o.load) else $error("second cycle");
	AST_PUSH_LIT: assert property (take_w && instr_i[15:8] == 8'hEA |=> mem_o.wr &&
		mem_o.addr == $past(pointer_register_two_o) && mem_o.data == $past(instr_i[7:0]) &&
		pointer_register_two_o == $past(pointer_register_two_o) - 12'h001) else $error("push literal");
	AST_CALL_ACC: assert property (take_w && instr_i == 16'h0014 |=> pc_o.push && pc_o.load && busy_o &&
		pc_o.value == {$past(program_counter_upper_latch_i[4:0]), $past(program_counter_high_latch_i),
		$past(accumulator_i)}) else $error("call through accumulator");
	AST_DISABLED: assert property (instr_valid_i && !ext_enable_i && !busy_o |=> !claimed_o)
		else $error("claimed while disabled");
endmodule : exd_decoder_sva

// ---- exd_decoder_bench.sv ----
// Self-checking bench for exd_decoder: a table of pointer ops, then hand tests.
// Assumes the design files and exd_decoder_sva.sv are compiled first.
`timescale 1ns/1ns
module exd_decoder_bench
	import exd_pkg::*;
;
	typedef struct packed {
		logic [15:0] w;
		logic        c;
		logic [11:0] p0;
		logic [11:0] p1;
		logic [11:0] p2;
	} exd_row_t;
	logic        sys_clk_i, reset_n_i, ext_enable_i, instr_valid_i, flags_we_o, claimed_o, busy_o;
	logic [15:0] instr_i;
	logic [20:0] pc_i, top_of_return_stack_i;
	logic [7:0]  accumulator_i, program_counter_high_latch_i, program_counter_upper_latch_i, mem_rdata_i;
	logic [11:0] pointer_register_0_o, pointer_register_1_o, pointer_register_two_o;
	exd_mem_t    mem_o;
	exd_pc_t     pc_o;
	int          err_count = 0;
	int          tests_run = 0;
	// Last two rows wrap ptr2 through zero to prove full-width carry
	exd_row_t    rows [9] = '{'{16'hE823, 1'b1, 12'h023, 12'h000, 12'h000}, '{16'hE87F, 1'b1, 12'h023, 12'h03F, 12'h000},
		'{16'hE8BF, 1'b1, 12'h023, 12'h03F, 12'h03F}, '{16'hE901, 1'b1, 12'h022, 12'h03F, 12'h03F},
		'{16'hE941, 1'b1, 12'h022, 12'h03E, 12'h03F}, '{16'hE9BF, 1'b1, 12'h022, 12'h03E, 12'h000},
		'{16'h1234, 1'b0, 12'h022, 12'h03E, 12'h000}, '{16'hE9A1, 1'b1, 12'h022, 12'h03E, 12'hFDF},
		'{16'hE8A1, 1'b1, 12'h022, 12'h03E, 12'h000}};
	exd_decoder exd_decoder_i (.*);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Outputs of the word are settled at the negedge where op returns
	task automatic op(logic [15:0] w);
		@(negedge sys_clk_i);
		instr_i = w;
		instr_valid_i = 1'b1;
		@(negedge sys_clk_i);
		instr_valid_i = 1'b0;
	endtask : op
	task automatic results;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#100000;
		err_count++;
		results();
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{reset_n_i, instr_valid_i, instr_i, pc_i, program_counter_upper_latch_i} = '0;
		ext_enable_i = 1'b1;
		top_of_return_stack_i = 21'h012345;
		accumulator_i = 8'h06;
		program_counter_high_latch_i = 8'h10;
		mem_rdata_i = 8'h33;
		repeat (16) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		chk("reset", {claimed_o, pointer_register_two_o, pc_o}, 32'h0);
		foreach (rows[i]) begin
			op(rows[i].w);
			chk("claimed", claimed_o, rows[i].c);
			chk("ptr0", pointer_register_0_o, rows[i].p0);
			chk("ptr1", pointer_register_1_o, rows[i].p1);
			chk("ptr2", pointer_register_two_o, rows[i].p2);
		end
		for (int k = 0; k < 2; k++) begin
			op(k ? 16'hE9C5 : 16'hE8C5);
			chk("ret", {busy_o, pc_o}, {1'b1, 3'b101, 21'h012345});
			op(16'hF000);
			chk("nop", {claimed_o, busy_o, pc_o.load}, 3'b100);
		end
		chk("ptr2", pointer_register_two_o, 12'h000);
		op(16'h0014);
		chk("call", pc_o, {3'b110, 21'h001006});
		op(16'hF000);
		chk("call nop", {claimed_o, busy_o}, 2'b10);
		op(16'hE8BF);
		op(16'hE8BF);
		op(16'hE882);
		op(16'hEA55);
		chk("push", {mem_o, pointer_register_two_o}, {2'b01, 12'h080, 8'h55, 12'h07F});
		op(16'hEB05);
		chk("src rd", {mem_o.rd, mem_o.addr}, {1'b1, 12'h084});
		op(16'hF123);
		chk("abs wr", mem_o, {2'b01, 12'h123, 8'h33});
		op(16'hEB85);
		op(16'hF00A);
		chk("idx wr", mem_o, {2'b01, 12'h089, 8'h33});
		op(16'hE9BF);
		op(16'hE9BF);
		op(16'hE9BF);
		op(16'hE8A6);
		chk("ptr2 wrap", pointer_register_two_o, 12'hFE8);
		op(16'hEB00);
		op(16'hF200);
		chk("abs zero", mem_o, {2'b01, 12'h200, 8'h00});
		op(16'hEB80);
		op(16'hF001);
		chk("idx nop", mem_o, {2'b00, 12'hFE9, 8'h00});
		chk("flags", flags_we_o, 1'b0);
		ext_enable_i = 1'b0;
		op(16'hE823);
		chk("off", {claimed_o, pointer_register_0_o}, {1'b0, 12'h022});
		ext_enable_i = 1'b1;
		results();
	end
endmodule : exd_decoder_bench
bind exd_decoder exd_decoder_sva exd_decoder_sva_i (.*);
